/* File: rtl/sbsr_top.sv */
`include "sbsr_defines.svh"

// Operation
// - Summary bits follow their sources combinationally, never latched.
// - Clearing an event register clears its summary bit directly.
// - Message bit clears once all output messages are read.
// - Bit 7 is the enabled operation event summary.
// - Bit 6 is OR of summary bits ANDed with enable mask.
// - Rising edge of master summary raises the service request line.
// - Status query returns whole byte, bit 6 as master summary, clears nothing.
// - Serial poll clears the request flag, not the master summary.
// - Master summary holds until all enabled summary bits clear.
// - Bit 5 is the enabled standard event summary.
// - Bit 4 is set while output buffer holds data.
// - Enable mask written with bit 6 forced to zero and read back that way; writing zero clears it.
// - No new request from same summary bit until its register clears.
// - Serial poll returns status byte with bit 6 set if requesting.
// - Status query goes through the ordinary command path.
// - Completion-arm command sets standard event bit 0 when operation ends.
// - Commands keep being accepted while completion arm is pending.
// - Completion query leaves bit 0, holds bus, then returns 8'h31 (ASCII 1).
// - Standard summary is OR of event bits ANDed with their enables.
module sbsr_top
  import sbsr_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       arst_n_i,
  // Command path
  input  wire logic       cmd_valid_i,
  input  sbsr_cmd_t       cmd_code_i,
  input  wire logic [7:0] cmd_data_i,
  output logic            rsp_valid_o,
  output logic [7:0]      rsp_data_o,
  // Serial poll and request line
  input  wire logic       spoll_i,
  output logic [7:0]      spoll_byte_o,
  output logic            srq_o,
  // Status sources
  input  wire logic       oper_summary_i,
  output logic            oper_clear_o,
  input  wire logic       outbuf_nonempty_i,
  input  wire logic [7:0] std_event_set_i,
  // Operation tracking
  input  wire logic       op_busy_i,
  output logic            hold_bus_o,
  // Register views
  output logic [7:0]      status_summary_byte_o,
  output logic [7:0]      request_enable_mask_o
);

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  function automatic logic is_cmd(input logic v, input sbsr_cmd_t c,
                                  input sbsr_cmd_t t);
    is_cmd = v && (c == t);
  endfunction

  wire logic wr_sre   = is_cmd(cmd_valid_i, cmd_code_i, CMD_SRE_WR);
  wire logic rd_sre   = is_cmd(cmd_valid_i, cmd_code_i, CMD_SRE_RD);
  wire logic rd_stb   = is_cmd(cmd_valid_i, cmd_code_i, CMD_STB_RD);
  wire logic wr_ese   = is_cmd(cmd_valid_i, cmd_code_i, CMD_ESE_WR);
  wire logic rd_ese   = is_cmd(cmd_valid_i, cmd_code_i, CMD_ESE_RD);
  wire logic rd_esr   = is_cmd(cmd_valid_i, cmd_code_i, CMD_ESR_RD);
  wire logic do_cls   = is_cmd(cmd_valid_i, cmd_code_i, CMD_CLS);
  wire logic do_arm   = is_cmd(cmd_valid_i, cmd_code_i, CMD_DONE_ARM);
  wire logic do_qry   = is_cmd(cmd_valid_i, cmd_code_i, CMD_DONE_QRY);
  wire logic do_rst   = is_cmd(cmd_valid_i, cmd_code_i, CMD_RST);
  wire logic rsp_req  = rd_sre | rd_stb | rd_ese | rd_esr;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] sre_ff;
  logic [7:0] ese_ff;
  logic [7:0] ser_ff;
  logic [7:0] en_src_ff;
  logic       request_service_flag_ff;
  logic       arm_ff;
  logic [7:0] spoll_byte_ff;
  logic       rsp_valid_ff;
  logic [7:0] rsp_data_ff;
  sbsr_wait_t state_ff;
  sbsr_wait_t nxt_state;

  // ----------------------------------------
  // Summary byte
  // ----------------------------------------
  // standard summary
  wire logic standard_event_summary_bit = |(ser_ff & ese_ff);
  wire logic operation_summary_bit = oper_summary_i;
  wire logic message_available_flag = outbuf_nonempty_i;

  wire logic [7:0] sum_src = {operation_summary_bit, 1'b0,
                              standard_event_summary_bit,
                              message_available_flag, 4'h0};
  wire logic [7:0] en_src = sum_src & sre_ff;
  wire logic master_summary_flag = |en_src;
  wire logic [7:0] summary_byte = sum_src
                                | {1'b0, master_summary_flag, 6'h00};
  wire logic [7:0] src_rise = en_src & ~en_src_ff;
  wire logic       any_rise = |src_rise;

  // ----------------------------------------
  // Completion tracking
  // ----------------------------------------
  // completion fires when idle
  wire logic done_fire = arm_ff && !op_busy_i;
  wire logic reply_go  = (state_ff == ST_REPLY) && !rsp_req;

  wire logic       ser_clr = rd_esr | do_cls;
  wire logic [7:0] nxt_ser = (ser_ff & {8{~ser_clr}}) | std_event_set_i
                           | {7'h00, done_fire};

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (do_qry) begin
          nxt_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (do_rst) begin
          nxt_state = ST_IDLE;
        end else if (!op_busy_i) begin
          nxt_state = ST_REPLY;
        end
      end
      ST_REPLY: begin
        if (do_rst || reply_go) begin
          nxt_state = ST_IDLE;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  // ----------------------------------------
  // Response mux
  // ----------------------------------------
  // query via command path
  wire logic [7:0] rsp_mux = rd_sre ? sre_ff
                           : rd_ese ? ese_ff
                           : rd_esr ? ser_ff
                           : rd_stb ? summary_byte
                           : `SBSR_DONE_REPLY;

  // ----------------------------------------
  // Sequential
  // ----------------------------------------
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sre_ff <= `SBSR_SRE_RST;
      ese_ff <= `SBSR_ESE_RST;
      ser_ff <= `SBSR_SER_RST;
    end else begin
      if (wr_sre) begin
        sre_ff <= cmd_data_i & `SBSR_SRE_MASK;
      end
      if (wr_ese) begin
        ese_ff <= cmd_data_i;
      end
      ser_ff <= nxt_ser;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      en_src_ff               <= 8'h00;
      request_service_flag_ff <= 1'b0;
    end else begin
      en_src_ff <= en_src;
      if (any_rise) begin
        request_service_flag_ff <= 1'b1;
      end else if (spoll_i) begin
        request_service_flag_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      spoll_byte_ff <= 8'h00;
    end else if (spoll_i) begin
      spoll_byte_ff <= {summary_byte[7], request_service_flag_ff,
                        summary_byte[5:0]};
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      arm_ff   <= 1'b0;
      state_ff <= ST_IDLE;
    end else begin
      if (do_arm) begin
        arm_ff <= 1'b1;
      end else if (done_fire || do_rst) begin
        arm_ff <= 1'b0;
      end
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rsp_valid_ff <= 1'b0;
      rsp_data_ff  <= 8'h00;
    end else begin
      // Command answers win; the reply waits for a cycle with no command answer
      rsp_valid_ff <= rsp_req | reply_go;
      if (rsp_req || reply_go) begin
        rsp_data_ff <= rsp_mux;
      end
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign rsp_valid_o           = rsp_valid_ff;
  assign rsp_data_o            = rsp_data_ff;
  assign spoll_byte_o          = spoll_byte_ff;
  assign srq_o                 = request_service_flag_ff;
  assign oper_clear_o          = do_cls;
  assign hold_bus_o            = (state_ff != ST_IDLE);
  assign status_summary_byte_o = summary_byte;
  assign request_enable_mask_o = sre_ff;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);

  property p_msg_bit;
    status_summary_byte_o[`SBSR_BIT_MSG] == outbuf_nonempty_i;
  endproperty
  a_msg_bit: assert property (p_msg_bit)
    else $error("message bit does not follow buffer");

  property p_master;
    status_summary_byte_o[`SBSR_BIT_REQ] ==
      |(status_summary_byte_o & request_enable_mask_o & 8'hBF);
  endproperty
  a_master: assert property (p_master)
    else $error("master summary mismatch");

  property p_srq_rise;
    $rose(status_summary_byte_o[`SBSR_BIT_REQ]) |=> srq_o;
  endproperty
  a_srq_rise: assert property (p_srq_rise)
    else $error("no request after master summary rise");

  property p_poll_clr;
    spoll_i && !any_rise |=> !srq_o;
  endproperty
  a_poll_clr: assert property (p_poll_clr)
    else $error("poll did not clear request");

  property p_no_rerequest;
    !srq_o && !any_rise |=> !srq_o;
  endproperty
  a_no_rerequest: assert property (p_no_rerequest)
    else $error("request without new enabled edge");

  property p_poll_byte;
    spoll_i |=> spoll_byte_o[`SBSR_BIT_REQ] == $past(srq_o);
  endproperty
  a_poll_byte: assert property (p_poll_byte)
    else $error("poll byte bit 6 wrong");

  property p_stb_query;
    rd_stb |=> rsp_valid_o && rsp_data_o == $past(status_summary_byte_o);
  endproperty
  a_stb_query: assert property (p_stb_query)
    else $error("status query answer wrong");

  property p_sre_zero;
    wr_sre && cmd_data_i == 8'h00 |=> request_enable_mask_o == 8'h00;
  endproperty
  a_sre_zero: assert property (p_sre_zero)
    else $error("mask not cleared by zero");

  property p_done_set;
    arm_ff && !op_busy_i |=> ser_ff[`SBSR_BIT_OPDONE];
  endproperty
  a_done_set: assert property (p_done_set)
    else $error("completion bit not set");

  property p_query_hold;
    state_ff == ST_WAIT && op_busy_i && !do_rst |=> hold_bus_o;
  endproperty
  a_query_hold: assert property (p_query_hold)
    else $error("bus released while busy");

  property p_query_reply;
    reply_go |=> rsp_valid_o && rsp_data_o == `SBSR_DONE_REPLY
                 && !hold_bus_o;
  endproperty
  a_query_reply: assert property (p_query_reply)
    else $error("completion reply missing");

  property p_std_summary;
    status_summary_byte_o[`SBSR_BIT_STD] == |(ser_ff & ese_ff);
  endproperty
  a_std_summary: assert property (p_std_summary)
    else $error("standard summary mismatch");

  property p_oper_bit;
    status_summary_byte_o[`SBSR_BIT_OPER] == oper_summary_i;
  endproperty
  a_oper_bit: assert property (p_oper_bit)
    else $error("operation summary bit does not follow source");

  // A read of the event register with no new event leaves it empty
  property p_esr_clear;
    rd_esr && std_event_set_i == 8'h00 && !done_fire |=> ser_ff == 8'h00;
  endproperty
  a_esr_clear: assert property (p_esr_clear)
    else $error("event register not cleared by read");

  property p_unsourced;
    status_summary_byte_o[3:0] == 4'h0 && !request_enable_mask_o[`SBSR_BIT_REQ];
  endproperty
  a_unsourced: assert property (p_unsourced)
    else $error("unsourced status or mask bit set");

  c_srq:   cover property (any_rise ##1 srq_o ##[1:20] spoll_i);
  c_rst:   cover property (hold_bus_o && do_rst);
  c_reply: cover property (do_qry ##[1:50] reply_go);
  c_esr:   cover property (srq_o ##[1:20] rd_esr);
  c_arm:   cover property (do_arm ##[1:50] done_fire);

endmodule // sbsr_top

/* File: include/sbsr_defines.svh */
`ifndef SBSR_DEFINES_SVH
`define SBSR_DEFINES_SVH

// ----------------------------------------
// Status byte field positions
// ----------------------------------------
`define SBSR_BIT_OPER    7
`define SBSR_BIT_REQ     6
`define SBSR_BIT_STD     5
`define SBSR_BIT_MSG     4
`define SBSR_BIT_OPDONE  0

// ----------------------------------------
// Reset values and masks
// ----------------------------------------
`define SBSR_SRE_RST     8'h00
`define SBSR_ESE_RST     8'h00
`define SBSR_SER_RST     8'h00
`define SBSR_SRE_MASK    8'hBF
`define SBSR_DONE_REPLY  8'h31

`endif

/* File: include/sbsr_pkg.sv */
package sbsr_pkg;

  // ----------------------------------------
  // Command codes
  // ----------------------------------------
  typedef enum logic [3:0] {
    CMD_NONE       = 4'h0,
    CMD_SRE_WR     = 4'h1,
    CMD_SRE_RD     = 4'h2,
    CMD_STB_RD     = 4'h3,
    CMD_ESE_WR     = 4'h4,
    CMD_ESE_RD     = 4'h5,
    CMD_ESR_RD     = 4'h6,
    CMD_CLS        = 4'h7,
    CMD_DONE_ARM   = 4'h8,
    CMD_DONE_QRY   = 4'h9,
    CMD_RST        = 4'hA
  } sbsr_cmd_t;

  // ----------------------------------------
  // Completion query states
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_WAIT  = 3'b010,
    ST_REPLY = 3'b100
  } sbsr_wait_t;

endpackage

/* File: bench/sbsr_ctl_model.sv */
// ----------------------------------------
// Bus controller model
// ----------------------------------------
module sbsr_ctl_model
  import sbsr_pkg::*;
(
  // Device side
  input  wire logic       sys_clk_i,
  input  wire logic       hold_bus_i,
  // Controller requests
  output logic            cmd_valid_o,
  output sbsr_cmd_t       cmd_code_o,
  output logic [7:0]      cmd_data_o,
  output logic            spoll_o
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    cmd_valid_o = 1'b0;
    cmd_code_o  = CMD_NONE;
    cmd_data_o  = 8'h00;
    spoll_o     = 1'b0;
  end

  // Caller stands just after an edge; valid stays up for back-to-back use
  task automatic send(input sbsr_cmd_t c, input logic [7:0] d);
    while (hold_bus_i !== 1'b0 && c != CMD_RST) begin
      @(posedge sys_clk_i);
      #1;
    end
    cmd_valid_o = 1'b1;
    cmd_code_o  = c;
    cmd_data_o  = d;
    @(posedge sys_clk_i);
    #1;
  endtask

  // Released data shows a changed pattern, not the old byte
  task automatic idle();
    cmd_valid_o = 1'b0;
    cmd_code_o  = CMD_NONE;
    cmd_data_o  = ~cmd_data_o;
  endtask

  task automatic poll();
    spoll_o = 1'b1;
    @(posedge sys_clk_i);
    #1;
    spoll_o = 1'b0;
  endtask
endmodule // sbsr_ctl_model

/* File: bench/status_byte_service_request_test.sv */
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin err_total++; \
  $display("[FAIL] %0t got %h exp %h", $time, got, exp); end end

module status_byte_service_request_test;
  import sbsr_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct packed {
    logic       oper;
    logic       ob;
    logic [7:0] sre;
    logic [7:0] exp;
  } sbsr_row_t;

  // Row 4: mask bit 6 alone has no effect; rows 5-6: unsourced bits read zero
  sbsr_row_t rows [7] = '{'{1'b1, 1'b0, 8'h00, 8'h80}, '{1'b0, 1'b1, 8'h10, 8'h50},
                          '{1'b1, 1'b1, 8'h80, 8'hD0}, '{1'b0, 1'b1, 8'h40, 8'h10},
                          '{1'b0, 1'b0, 8'hFF, 8'h00}, '{1'b1, 1'b0, 8'h0F, 8'h80},
                          '{1'b1, 1'b1, 8'h00, 8'h90}};

  logic       sys_clk_i = 1'b0;
  logic       arst_n_i;
  logic       cmd_valid_i, spoll_i, oper_summary_i, outbuf_nonempty_i, op_busy_i;
  sbsr_cmd_t  cmd_code_i;
  logic [7:0] cmd_data_i, std_event_set_i, rsp_data_o, spoll_byte_o;
  logic [7:0] status_summary_byte_o, request_enable_mask_o;
  logic       rsp_valid_o, srq_o, oper_clear_o, hold_bus_o;
  int         err_total  = 0;
  int         n_compared = 0;
  int         cyc_cnt    = 0;

  always #5 sys_clk_i = ~sys_clk_i;

  sbsr_ctl_model ctl (.sys_clk_i(sys_clk_i), .hold_bus_i(hold_bus_o), .cmd_valid_o(cmd_valid_i),
                      .cmd_code_o(cmd_code_i), .cmd_data_o(cmd_data_i), .spoll_o(spoll_i));

  sbsr_top DUT (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .cmd_valid_i(cmd_valid_i),
                .cmd_code_i(cmd_code_i), .cmd_data_i(cmd_data_i), .rsp_valid_o(rsp_valid_o),
                .rsp_data_o(rsp_data_o), .spoll_i(spoll_i), .spoll_byte_o(spoll_byte_o),
                .srq_o(srq_o), .oper_summary_i(oper_summary_i), .oper_clear_o(oper_clear_o),
                .outbuf_nonempty_i(outbuf_nonempty_i), .std_event_set_i(std_event_set_i),
                .op_busy_i(op_busy_i), .hold_bus_o(hold_bus_o),
                .status_summary_byte_o(status_summary_byte_o),
                .request_enable_mask_o(request_enable_mask_o));

  task automatic tally_and_finish();
    if (err_total == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask

  task automatic rd(input sbsr_cmd_t c, input logic [7:0] exp);
    ctl.send(c, 8'h00);
    // Answer valid stands for one cycle only
    `CHK(rsp_valid_o, 1'b1)
    `CHK(rsp_data_o, exp)
    ctl.idle();
    tick(1);
  endtask

  task automatic pulse_event();
    std_event_set_i = 8'h20;
    tick(1);
    std_event_set_i = 8'h00;
    tick(1);
  endtask

  // Hang guard, the whole run needs about a hundred cycles
  always @(posedge sys_clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 3000) begin
      err_total++;
      tally_and_finish();
    end
  end

  initial begin
    arst_n_i          = 1'b0;
    oper_summary_i    = 1'b0;
    outbuf_nonempty_i = 1'b0;
    op_busy_i         = 1'b0;
    std_event_set_i   = 8'h00;
    repeat (3) @(posedge sys_clk_i);
    #1;
    arst_n_i = 1'b1;
    `CHK({srq_o, hold_bus_o, rsp_valid_o, request_enable_mask_o}, 11'h000)
    // ----------------------------------------
    // Table of summary and mask cases
    // ----------------------------------------
    foreach (rows[i]) begin
      oper_summary_i    = rows[i].oper;
      outbuf_nonempty_i = rows[i].ob;
      ctl.send(CMD_SRE_WR, rows[i].sre);
      ctl.idle();
      tick(1);
      `CHK(status_summary_byte_o, rows[i].exp)
      rd(CMD_SRE_RD, rows[i].sre & 8'hBF);
      rd(CMD_STB_RD, rows[i].exp);
      `CHK(status_summary_byte_o, rows[i].exp)
    end
    // ----------------------------------------
    // Request line and serial poll
    // ----------------------------------------
    oper_summary_i    = 1'b0;
    outbuf_nonempty_i = 1'b0;
    ctl.poll();
    tick(1);
    `CHK(status_summary_byte_o, 8'h00)
    ctl.send(CMD_ESE_WR, 8'h20);
    ctl.send(CMD_SRE_WR, 8'h20);
    rd(CMD_ESE_RD, 8'h20);
    rd(CMD_ESR_RD, 8'h00);
    pulse_event();
    `CHK(srq_o, 1'b1)
    `CHK(status_summary_byte_o, 8'h60)
    ctl.poll();
    tick(1);
    `CHK(spoll_byte_o, 8'h60)
    `CHK({srq_o, status_summary_byte_o[6]}, 2'b01)
    pulse_event();
    `CHK(srq_o, 1'b0)
    rd(CMD_ESR_RD, 8'h20);
    `CHK(status_summary_byte_o, 8'h00)
    pulse_event();
    `CHK(srq_o, 1'b1)
    ctl.send(CMD_SRE_WR, 8'h00);
    ctl.idle();
    tick(1);
    `CHK(status_summary_byte_o, 8'h20)
    ctl.send(CMD_CLS, 8'h00);
    `CHK(oper_clear_o, 1'b1)
    ctl.idle();
    tick(1);
    `CHK({oper_clear_o, status_summary_byte_o}, 9'h000)
    ctl.poll();
    // ----------------------------------------
    // Completion arm and query
    // ----------------------------------------
    op_busy_i = 1'b1;
    ctl.send(CMD_ESE_WR, 8'h01);
    ctl.send(CMD_DONE_ARM, 8'h00);
    ctl.idle();
    tick(3);
    rd(CMD_SRE_RD, 8'h00);
    `CHK(status_summary_byte_o[5], 1'b0)
    op_busy_i = 1'b0;
    tick(3);
    `CHK(status_summary_byte_o[5], 1'b1)
    rd(CMD_ESR_RD, 8'h01);
    op_busy_i = 1'b1;
    ctl.send(CMD_DONE_QRY, 8'h00);
    ctl.idle();
    tick(4);
    `CHK({hold_bus_o, rsp_valid_o}, 2'b10)
    op_busy_i = 1'b0;
    for (int k = 0; k < 6 && rsp_valid_o !== 1'b1; k++) tick(1);
    `CHK({rsp_valid_o, hold_bus_o, rsp_data_o}, 10'h231)
    rd(CMD_ESR_RD, 8'h00);
    op_busy_i = 1'b1;
    ctl.send(CMD_DONE_QRY, 8'h00);
    ctl.idle();
    tick(2);
    ctl.send(CMD_RST, 8'h00);
    ctl.idle();
    tick(1);
    `CHK(hold_bus_o, 1'b0)
    tally_and_finish();
  end
endmodule // status_byte_service_request_test
